//--- tdmec_pkg.sv
package tdmec_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_MODE      = 8'h04;
	localparam logic [7:0] OFS_INT_EN    = 8'h10;
	localparam logic [7:0] OFS_INT_DIS   = 8'h14;
	localparam logic [7:0] OFS_INT_MASK  = 8'h18;
	localparam logic [7:0] OFS_INT_STAT  = 8'h1C;
	localparam logic [7:0] OFS_KEY_FIRST = 8'h20;
	localparam logic [7:0] OFS_KEY_LAST  = 8'h34;
	localparam logic [7:0] OFS_IN_DATA1  = 8'h40;
	localparam logic [7:0] OFS_IN_DATA2  = 8'h44;
	localparam logic [7:0] OFS_OUT_DATA1 = 8'h50;
	localparam logic [7:0] OFS_OUT_DATA2 = 8'h54;
	localparam logic [7:0] OFS_IV1       = 8'h60;
	localparam logic [7:0] OFS_IV2       = 8'h64;
	// control bits
	localparam int BIT_START = 0;
	localparam int BIT_SOFT_RESET_CMD = 8;
	// mode field positions
	localparam int BIT_CIPHER  = 0;
	localparam int BIT_TRIPLE  = 1;
	localparam int BIT_KEYCNT  = 4;
	localparam int POS_START_M = 8;
	localparam int POS_CHAIN_M = 12;
	localparam int BIT_LOD     = 15;
	localparam int POS_FB_SIZE = 16;
	localparam logic [31:0] MODE_RESET    = 32'h0000_0002;
	localparam logic [31:0] MODE_WR_MASK  = 32'h0003_B313;
	// status bit positions
	localparam int BIT_RDY   = 0;
	localparam int BIT_RXEND = 1;
	localparam int BIT_TXEND = 2;
	localparam int BIT_RXFUL = 3;
	localparam int BIT_TXEMP = 4;
	localparam int BIT_ILLEGAL_ACCESS_FLAG  = 8;
	localparam int POS_ILLEGAL_ACCESS_TYPE  = 12;
	localparam logic [8:0] INT_BITS_MASK = 9'h11F;
	// illegal access causes
	localparam logic [1:0] ILLEGAL_ACCESS_TYPE_IN_DMA   = 2'h0;
	localparam logic [1:0] ILLEGAL_ACCESS_TYPE_OUT_BUSY = 2'h1;
	localparam logic [1:0] ILLEGAL_ACCESS_TYPE_MODE_BSY = 2'h2;
	localparam logic [1:0] ILLEGAL_ACCESS_TYPE_WO_READ  = 2'h3;
	typedef enum logic [1:0] {SM_MANUAL, SM_AUTO, SM_DMA, SM_RSVD} tdmec_start_t;
	typedef enum logic [1:0] {CH_ECB, CH_CBC, CH_OFB, CH_CFB} tdmec_chain_t;
	typedef enum logic [1:0] {FB_64, FB_32, FB_16, FB_8} tdmec_fb_t;
	// core completion latency in clocks; arbitrary stand-in for the rounds
	localparam logic [5:0] CORE_CYCLES = 6'h10;
endpackage

//--- tdmec_core_timer.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the cipher rounds: busy for a fixed count after a start
module tdmec_core_timer
	import tdmec_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// control
	input  wire logic start,
	input  wire logic abort,
	output logic      busy,
	output logic      done
);
	logic [5:0] cnt_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 6'h00;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy    <= 1'b0;
				cnt_reg <= 6'h00;
			end else if (start) begin
				busy    <= 1'b1;
				cnt_reg <= CORE_CYCLES;
			end else if (busy) begin
				if (cnt_reg == 6'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				cnt_reg <= cnt_reg - 6'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- tdmec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tdmec_top
	import tdmec_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// dma counter state, same clock
	input  wire logic        rx_count_zero,
	input  wire logic        rx_next_count_zero,
	input  wire logic        tx_count_zero,
	input  wire logic        tx_next_count_zero,
	input  wire logic        rx_count_wr,
	input  wire logic        tx_count_wr,
	input  wire logic        dma_block_req,
	// engine configuration
	output logic             cipher_encrypt,
	output logic             triple_select,
	output logic             key_count_select,
	output logic [1:0]       start_mode_select,
	output logic [1:0]       chaining_mode_select,
	output logic             last_output_mode,
	output logic [1:0]       feedback_size_select,
	output logic [6:0]       feedback_bits,
	output logic [1:0]       active_key_count,
	output logic             results_to_memory,
	output logic             core_start,
	output logic             irq
);
	logic [31:0] mode_reg;
	logic [8:0]  mask_reg;
	logic        rdy_reg;
	logic        rxend_reg;
	logic        txend_reg;
	logic        rxful_reg;
	logic        txemp_reg;
	logic        illegal_access_flag_reg;
	logic [1:0]  illegal_access_type_reg;
	logic        in1_reg;
	logic        in2_reg;
	logic        busy;
	logic        done;
	logic        acc;
	logic        wr;
	logic        rd;
	logic [7:0]  ofs;
	logic        hit;
	logic        wo_reg_hit;
	logic        soft_reset_cmd;
	logic        man_start;
	logic        in_wr;
	logic        out_rd;
	logic        dma_mode;
	logic        auto_go;
	logic        go;
	logic [8:0]  stat;
	logic [31:0] rd_next;
	logic        illegal;
	logic [1:0]  illegal_code;

	// start-mode decode shared by every start path
	function automatic logic start_mode_is(input logic [31:0] mode, input tdmec_start_t sm);
		start_mode_is = mode[POS_START_M +: 2] == sm;
	endfunction

	// word-pair decode shared by the data, output and vector registers
	function automatic logic is_pair(input logic [7:0] a, input logic [7:0] first, input logic [7:0] second);
		is_pair = a == first || a == second;
	endfunction

	// single-cycle access: pready answers in the access phase
	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign ofs     = paddr[7:0];
	assign soft_reset_cmd   = wr && ofs == OFS_CONTROL && pwdata[BIT_SOFT_RESET_CMD];
	assign man_start = wr && ofs == OFS_CONTROL && pwdata[BIT_START]
		&& start_mode_is(mode_reg, SM_MANUAL);
	assign in_wr   = wr && is_pair(ofs, OFS_IN_DATA1, OFS_IN_DATA2);
	assign out_rd  = rd && is_pair(ofs, OFS_OUT_DATA1, OFS_OUT_DATA2);
	assign dma_mode = start_mode_is(mode_reg, SM_DMA);

	function automatic logic [6:0] fb_width(input logic [1:0] sel);
		unique case (sel)
			FB_64:   fb_width = 7'd64;
			FB_32:   fb_width = 7'd32;
			FB_16:   fb_width = 7'd16;
			default: fb_width = 7'd8;
		endcase
	endfunction

	// write-only registers in the low map
	assign wo_reg_hit = ofs == OFS_CONTROL || is_pair(ofs, OFS_INT_EN, OFS_INT_DIS)
		|| (ofs >= OFS_KEY_FIRST && ofs <= OFS_KEY_LAST && ofs[1:0] == 2'b00)
		|| is_pair(ofs, OFS_IN_DATA1, OFS_IN_DATA2) || is_pair(ofs, OFS_IV1, OFS_IV2);
	assign hit = paddr[31:8] == 24'h00_0000 && paddr[1:0] == 2'b00 && (wo_reg_hit
		|| ofs == OFS_MODE || ofs == OFS_INT_MASK || ofs == OFS_INT_STAT
		|| is_pair(ofs, OFS_OUT_DATA1, OFS_OUT_DATA2));

	// auto mode starts once both input words have been written
	assign auto_go = start_mode_is(mode_reg, SM_AUTO) && in_wr && !busy
		&& ((ofs == OFS_IN_DATA1 && in2_reg) || (ofs == OFS_IN_DATA2 && in1_reg));
	assign go = (man_start || auto_go || (dma_mode && dma_block_req)) && !busy;

	tdmec_core_timer u_core (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (go),
		.abort   (soft_reset_cmd),
		.busy    (busy),
		.done    (done)
	);

	// illegal access detection, first listed cause wins within a cycle by priority
	always_comb begin
		illegal      = 1'b0;
		illegal_code = ILLEGAL_ACCESS_TYPE_WO_READ;
		if (rd && hit && wo_reg_hit) begin
			illegal      = 1'b1;
			illegal_code = ILLEGAL_ACCESS_TYPE_WO_READ;
		end else if (wr && ofs == OFS_MODE && busy) begin
			illegal      = 1'b1;
			illegal_code = ILLEGAL_ACCESS_TYPE_MODE_BSY;
		end else if (out_rd && busy) begin
			illegal      = 1'b1;
			illegal_code = ILLEGAL_ACCESS_TYPE_OUT_BUSY;
		end else if (in_wr && busy && dma_mode) begin
			illegal      = 1'b1;
			illegal_code = ILLEGAL_ACCESS_TYPE_IN_DMA;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= MODE_RESET;
		end else if (soft_reset_cmd) begin
			mode_reg <= MODE_RESET;
		end else if (wr && ofs == OFS_MODE && !busy) begin
			// mode writes while busy are refused and flagged
			mode_reg <= pwdata & MODE_WR_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg <= 9'h000;
		end else if (soft_reset_cmd) begin
			mask_reg <= 9'h000;
		end else if (wr && ofs == OFS_INT_EN) begin
			mask_reg <= mask_reg | (pwdata[8:0] & INT_BITS_MASK);
		end else if (wr && ofs == OFS_INT_DIS) begin
			mask_reg <= mask_reg & ~(pwdata[8:0] & INT_BITS_MASK);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			in1_reg <= 1'b0;
			in2_reg <= 1'b0;
		end else if (soft_reset_cmd || go) begin
			in1_reg <= 1'b0;
			in2_reg <= 1'b0;
		end else if (in_wr) begin
			in1_reg <= in1_reg | (ofs == OFS_IN_DATA1);
			in2_reg <= in2_reg | (ofs == OFS_IN_DATA2);
		end
	end

	// result ready: completion set wins over any same-cycle clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdy_reg <= 1'b0;
		end else if (done) begin
			rdy_reg <= 1'b1;
		end else if (soft_reset_cmd) begin
			rdy_reg <= 1'b0;
		end else if (dma_mode) begin
			if (go)
				rdy_reg <= 1'b0;
		end else if (man_start) begin
			rdy_reg <= 1'b0;
		end else if (!mode_reg[BIT_LOD] && out_rd) begin
			rdy_reg <= 1'b0;
		end else if (mode_reg[BIT_LOD] && in_wr) begin
			rdy_reg <= 1'b0;
		end
	end

	// dma buffer flags from same-clock counter indications; zero beats a same-cycle counter write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxend_reg <= 1'b1;
		end else if (rx_count_zero) begin
			rxend_reg <= 1'b1;
		end else if (rx_count_wr) begin
			rxend_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			txend_reg <= 1'b1;
		end else if (tx_count_zero) begin
			txend_reg <= 1'b1;
		end else if (tx_count_wr) begin
			txend_reg <= 1'b0;
		end
	end

	// fullness flags are plain levels, so a counter write needs no extra handling
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxful_reg <= 1'b1;
		end else begin
			rxful_reg <= rx_count_zero && rx_next_count_zero;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			txemp_reg <= 1'b1;
		end else begin
			txemp_reg <= tx_count_zero && tx_next_count_zero;
		end
	end

	// sticky illegal access flag; event beats a same-cycle soft reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			illegal_access_flag_reg <= 1'b0;
		end else if (illegal) begin
			illegal_access_flag_reg <= 1'b1;
		end else if (soft_reset_cmd) begin
			illegal_access_flag_reg <= 1'b0;
		end
	end

	// cause of the latest illegal access, same priority as the flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			illegal_access_type_reg <= 2'b00;
		end else if (illegal) begin
			illegal_access_type_reg <= illegal_code;
		end else if (soft_reset_cmd) begin
			illegal_access_type_reg <= 2'b00;
		end
	end

	assign stat = {illegal_access_flag_reg, 3'b000, txemp_reg, rxful_reg, txend_reg, rxend_reg, rdy_reg};

	always_comb begin
		rd_next = 32'h0000_0000;
		if (ofs == OFS_INT_MASK)
			rd_next = {23'h00_0000, mask_reg};
		else if (ofs == OFS_INT_STAT)
			rd_next = {18'h0_0000, illegal_access_type_reg, 3'b000, stat};
		else if (ofs == OFS_MODE)
			rd_next = mode_reg;
	end

	// bus answer registered; output data words live in the datapath
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !pready;
			pslverr <= psel && !pready && !hit;
			prdata  <= (psel && !pwrite && hit) ? rd_next : 32'h0000_0000;
		end
	end

	// registered copies of the mode fields
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cipher_encrypt       <= 1'b0;
			triple_select        <= 1'b1;
			key_count_select     <= 1'b0;
			start_mode_select    <= 2'b00;
			chaining_mode_select <= 2'b00;
			last_output_mode     <= 1'b0;
			feedback_size_select <= 2'b00;
		end else begin
			cipher_encrypt       <= mode_reg[BIT_CIPHER];
			triple_select        <= mode_reg[BIT_TRIPLE];
			key_count_select     <= mode_reg[BIT_KEYCNT];
			start_mode_select    <= mode_reg[POS_START_M +: 2];
			chaining_mode_select <= mode_reg[POS_CHAIN_M +: 2];
			last_output_mode     <= mode_reg[BIT_LOD];
			feedback_size_select <= mode_reg[POS_FB_SIZE +: 2];
		end
	end

	// settings derived from the mode fields, same latency as the copies
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			feedback_bits     <= 7'd64;
			active_key_count  <= 2'd3;
			results_to_memory <= 1'b0;
		end else begin
			feedback_bits     <= fb_width(mode_reg[POS_FB_SIZE +: 2]);
			// two-key operation reuses key one, so third key words are ignored
			active_key_count  <= !mode_reg[BIT_TRIPLE] ? 2'd1
				: (mode_reg[BIT_KEYCNT] ? 2'd2 : 2'd3);
			results_to_memory <= dma_mode && !mode_reg[BIT_LOD];
		end
	end

	// start pulse and interrupt request
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_start <= 1'b0;
			irq        <= 1'b0;
		end else begin
			core_start <= go;
			irq        <= |(stat & mask_reg);
		end
	end
endmodule
`default_nettype wire

//--- tdmec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tdmec_checker
	import tdmec_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// engine configuration
	input  wire logic        triple_select,
	input  wire logic        key_count_select,
	input  wire logic [1:0]  start_mode_select,
	input  wire logic        last_output_mode,
	input  wire logic [1:0]  feedback_size_select,
	input  wire logic [6:0]  feedback_bits,
	input  wire logic [1:0]  active_key_count,
	input  wire logic        results_to_memory,
	input  wire logic        core_start,
	input  wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire setup = psel && !penable;
	wire ctl_wr = setup && pwrite && paddr == 32'h0000_0000;
	ready_after_setup_a: assert property (setup |=> pready) else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	fb_size_map_a: assert property ($stable(feedback_size_select) |->
		feedback_bits == (7'h40 >> feedback_size_select)) else $error("feedback width wrong");
	key_count_map_a: assert property ($stable({triple_select, key_count_select}) |->
		active_key_count == (!triple_select ? 2'h1 : (key_count_select ? 2'h2 : 2'h3)))
		else $error("key count wrong");
	mem_route_a: assert property ($stable({start_mode_select, last_output_mode}) |->
		results_to_memory == (start_mode_select == 2'h2 && !last_output_mode)) else $error("result route wrong");
	start_kick_a: assert property (ctl_wr && pwdata[0] && start_mode_select == 2'h0 |-> ##[1:4] core_start)
		else $error("manual start did not start core");
	start_pulse_a: assert property (core_start |=> !core_start) else $error("core start not a pulse");
	irq_quiet_a: assert property (ctl_wr && pwdata[8] |-> ##4 !irq) else $error("irq after soft reset");
	cover property (results_to_memory);
	cover property (irq);
	cover property (pslverr);
	cover property (core_start);
endmodule
bind tdmec_top tdmec_checker i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.triple_select(triple_select), .key_count_select(key_count_select), .start_mode_select(start_mode_select),
	.last_output_mode(last_output_mode), .feedback_size_select(feedback_size_select),
	.feedback_bits(feedback_bits), .active_key_count(active_key_count), .results_to_memory(results_to_memory),
	.core_start(core_start), .irq(irq));
`default_nettype wire

//--- tdmec_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
module tdmec_dma_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// bench control
	input  wire logic       load,
	input  wire logic [3:0] load_count,
	// counter state towards the block
	output logic            rx_count_zero,
	output logic            rx_next_count_zero,
	output logic            tx_count_zero,
	output logic            tx_next_count_zero,
	output logic            rx_count_wr,
	output logic            tx_count_wr,
	output logic            dma_block_req
);
	logic [3:0] cnt_reg;
	logic       wr_reg;
	// one word a clock on both channels; next counters stay empty
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 4'h0;
		end else if (load) begin
			cnt_reg <= load_count;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	// write pulse lands once the counter is loaded, so zero cannot mask it
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= 1'b0;
		end else begin
			wr_reg <= load;
		end
	end
	assign rx_count_zero      = (cnt_reg == 4'h0);
	assign tx_count_zero      = (cnt_reg == 4'h0);
	assign rx_next_count_zero = 1'b1;
	assign tx_next_count_zero = 1'b1;
	assign rx_count_wr        = wr_reg;
	assign tx_count_wr        = wr_reg;
	assign dma_block_req      = (cnt_reg == 4'h1);
endmodule
`default_nettype wire

//--- triple_des_mode_and_event_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module triple_des_mode_and_event_control_tb_top;
	import tdmec_pkg::*;
	logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, load, rtm, enc;
	logic        rxz, rxnz, txz, txnz, rxw, txw, breq;
	logic [31:0] paddr, pwdata, prdata, rd_data;
	logic [3:0]  load_count;
	logic [6:0]  fbits;
	logic [1:0]  chain, keys;
	int          fail_count = 0;
	int          checks_done = 0;
	tdmec_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_count_zero(rxz), .rx_next_count_zero(rxnz), .tx_count_zero(txz), .tx_next_count_zero(txnz),
		.rx_count_wr(rxw), .tx_count_wr(txw), .dma_block_req(breq), .cipher_encrypt(enc), .triple_select(),
		.key_count_select(), .start_mode_select(), .chaining_mode_select(chain), .last_output_mode(),
		.feedback_size_select(), .feedback_bits(fbits), .active_key_count(keys), .results_to_memory(rtm),
		.core_start(), .irq(irq));
	tdmec_dma_model i_dma (.ref_clk(ref_clk), .arst_n(arst_n), .load(load), .load_count(load_count),
		.rx_count_zero(rxz), .rx_next_count_zero(rxnz), .tx_count_zero(txz), .tx_next_count_zero(txnz),
		.rx_count_wr(rxw), .tx_count_wr(txw), .dma_block_req(breq));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {24'h00_0000, adr};
		pwdata <= dat;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		if (pready !== 1'b1) test_done();
		rd_data = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
		apb(1'b0, adr, 32'h0);
		chk(nm, exp, rd_data & msk);
	endtask
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_INT_STAT, 32'h0);
			n++;
		end while (rd_data[b] !== 1'b1 && n < 40);
		chk("status bit", 32'h1, {31'h0, rd_data[b]});
		if (rd_data[b] !== 1'b1) test_done();
	endtask
	task automatic t_reset();
		rd("mode", OFS_MODE, MODE_RESET, 32'hFFFF_FFFF);
		rd("mask", OFS_INT_MASK, 32'h0, 32'hFFFF_FFFF);
		rd("status", OFS_INT_STAT, 32'h0000_001E, 32'hFFFF_FFFF);
		apb(1'b0, 8'h08, 32'h0);
		chk("reserved slverr", 32'h1, {31'h0, pslverr});
	endtask
	task automatic t_irq();
		apb(1'b1, OFS_INT_EN, 32'h0000_011F);
		rd("mask", OFS_INT_MASK, 32'h0000_011F, 32'hFFFF_FFFF);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, OFS_INT_EN, 32'h0);
		rd("mask", OFS_INT_MASK, 32'h0000_011F, 32'hFFFF_FFFF);
		apb(1'b1, OFS_INT_DIS, 32'h0000_0006);
		rd("mask", OFS_INT_MASK, 32'h0000_0119, 32'hFFFF_FFFF);
		apb(1'b1, OFS_INT_DIS, 32'h0000_011F);
		rd("mask", OFS_INT_MASK, 32'h0, 32'hFFFF_FFFF);
		chk("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_mode();
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			d = (i << POS_CHAIN_M) | (i << POS_FB_SIZE) | ((i & 1) << BIT_KEYCNT) | ((i != 3) << BIT_TRIPLE)
				| ((i >> 1) << BIT_CIPHER);
			apb(1'b1, OFS_MODE, d);
			rd("mode", OFS_MODE, d, MODE_WR_MASK);
			chk("chain", i, {30'h0, chain});
			chk("fb bits", 32'h40 >> i, {25'h0, fbits});
			chk("keys", (i == 3) ? 1 : ((i & 1) ? 2 : 3), {30'h0, keys});
			chk("cipher", i >> 1, {31'h0, enc});
		end
	endtask
	task automatic t_manual();
		apb(1'b1, OFS_MODE, 32'h0000_0002);
		apb(1'b1, OFS_INT_EN, 32'h0000_0001);
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		wait_bit(BIT_RDY);
		chk("irq", 32'h1, {31'h0, irq});
		rd("out", OFS_OUT_DATA1, 32'h0, 32'h0);
		rd("ready", OFS_INT_STAT, 32'h0, 32'h0000_0001);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		wait_bit(BIT_RDY);
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		rd("ready", OFS_INT_STAT, 32'h0, 32'h0000_0001);
		wait_bit(BIT_RDY);
	endtask
	task automatic t_lod();
		apb(1'b1, OFS_MODE, 32'h0000_8002);
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		wait_bit(BIT_RDY);
		rd("out", OFS_OUT_DATA2, 32'h0, 32'h0);
		rd("ready", OFS_INT_STAT, 32'h1, 32'h0000_0001);
		apb(1'b1, OFS_IN_DATA1, 32'h0);
		rd("ready", OFS_INT_STAT, 32'h0, 32'h0000_0001);
	endtask
	task automatic t_illegal();
		apb(1'b0, OFS_INT_EN, 32'h0);
		rd("illegal", OFS_INT_STAT, 32'h0000_3100, 32'h0000_3100);
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		apb(1'b1, OFS_MODE, 32'h0000_0002);
		rd("illegal", OFS_INT_STAT, 32'h0000_2100, 32'h0000_3100);
		rd("out busy", OFS_OUT_DATA1, 32'h0, 32'h0);
		rd("illegal", OFS_INT_STAT, 32'h0000_1100, 32'h0000_3100);
		rd("mode kept", OFS_MODE, 32'h0000_8002, MODE_WR_MASK);
		wait_bit(BIT_RDY);
		apb(1'b1, OFS_CONTROL, 32'h0000_0100);
		rd("soft reset", OFS_INT_STAT, 32'h0, 32'h0000_3101);
	endtask
	task automatic t_auto();
		apb(1'b1, OFS_MODE, 32'h0000_0102);
		apb(1'b1, OFS_IN_DATA1, 32'h0);
		apb(1'b1, OFS_IN_DATA2, 32'h0);
		wait_bit(BIT_RDY);
		rd("out", OFS_OUT_DATA2, 32'h0, 32'h0);
		rd("ready", OFS_INT_STAT, 32'h0, 32'h0000_0001);
	endtask
	task automatic t_dma();
		apb(1'b1, OFS_MODE, 32'h0000_0202);
		repeat (2) @(posedge ref_clk);
		chk("to memory", 32'h1, {31'h0, rtm});
		@(posedge ref_clk);
		load <= 1'b1;
		load_count <= 4'hC;
		@(posedge ref_clk);
		load <= 1'b0;
		rd("busy buffers", OFS_INT_STAT, 32'h0, 32'h0000_001E);
		wait_bit(BIT_RXEND);
		rd("done buffers", OFS_INT_STAT, 32'h0000_001E, 32'h0000_001E);
		apb(1'b1, OFS_IN_DATA1, 32'h0);
		rd("illegal", OFS_INT_STAT, 32'h0000_0100, 32'h0000_3100);
		wait_bit(BIT_RDY);
		rd("out", OFS_OUT_DATA1, 32'h0, 32'h0);
		rd("dma ready", OFS_INT_STAT, 32'h1, 32'h0000_0001);
		apb(1'b1, OFS_MODE, 32'h0000_8202);
		repeat (2) @(posedge ref_clk);
		chk("to memory", 32'h0, {31'h0, rtm});
	endtask
	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, load} = 4'h0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		load_count = 4'h0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_irq();
		t_mode();
		t_manual();
		t_lod();
		t_illegal();
		t_auto();
		t_dma();
		test_done();
	end
endmodule
`default_nettype wire
